// *** rtl/slc_regs.svh ***
`ifndef SLC_REGS_SVH
`define SLC_REGS_SVH
// Register word offsets on the plain register port.
`define SLC_A_FEATURE 8'h00
`define SLC_A_LBA_LO 8'h01
`define SLC_A_LBA_HI 8'h02
`define SLC_A_CMD 8'h03
`define SLC_A_DATA 8'h04
`define SLC_A_STATUS 8'h05
`define SLC_A_CONFIG 8'h06
`define SLC_A_ERASE_TIME 8'h07
`define SLC_A_PW_BASE 8'h20
// Opcodes and sanitize features.
`define SLC_OP_SANITIZE 8'hB4
`define SLC_OP_DISABLE_PW 8'hF6
`define SLC_OP_ERASE_PREP 8'hF3
`define SLC_OP_ERASE_UNIT 8'hF4
`define SLC_FEAT_FREEZE 16'h0020
`define SLC_FEAT_STATUS 16'h0000
`define SLC_FREEZE_KEY 32'h46724C6B
// Password sector layout.
`define SLC_SECTOR_WORDS 9'h100
`define SLC_PW_WORDS 16
`define SLC_CTL_ID_BIT 0
`define SLC_CTL_ENH_BIT 1
// Config register bits.
`define SLC_CF_SAN_SUP 0
`define SLC_CF_ANTIFREEZE 1
`define SLC_CF_OVERRIDE 2
`define SLC_CF_ENH_SUP 3
`define SLC_CF_SEC_EN 4
`define SLC_CF_LOCKED 5
`define SLC_CF_FROZEN 6
// Status register bits.
`define SLC_ST_BUSY 0
`define SLC_ST_DRQ 1
`define SLC_ST_DONE 2
`define SLC_ST_ABORT 3
`define SLC_ST_ERR 4
`define SLC_ST_SFROZEN 5
`define SLC_ST_PREP 6
`define SLC_ST_FROZEN 7
`define SLC_ST_FWD 8
// Reset values.
`define SLC_CONFIG_RST 7'h00
`define SLC_ERASE_TIME_RST 16'h0000
`endif

// *** rtl/slc_pkg.sv ***
package slc_pkg;
  typedef logic [15:0] slc_word_t;
  typedef logic [255:0] slc_pw_t;
  typedef logic [47:0] slc_lba_t;
  typedef enum logic [2:0] {
    SLC_IDLE = 3'b000,
    SLC_DATA = 3'b001,
    SLC_CMP = 3'b010,
    SLC_DECIDE = 3'b011,
    SLC_ERASE = 3'b100,
    SLC_EWAIT = 3'b101
  } slc_state_t;
endpackage

// *** rtl/slc_pw_cmp.sv ***
`timescale 1ns/100ps
`include "slc_regs.svh"
module slc_pw_cmp (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire slc_pkg::slc_pw_t given_i,
  input wire slc_pkg::slc_pw_t stored_i,
  output logic match_o,
  output logic invalid_o
);
  import slc_pkg::*;

  logic [`SLC_PW_WORDS-1:0] eq_w;
  logic [`SLC_PW_WORDS-1:0] zero_w;

  // Every one of the 32 bytes takes part; nothing is masked.
  genvar g;
  generate
    for (g = 0; g < `SLC_PW_WORDS; g++) begin : g_word
      assign eq_w[g] = given_i[16*g +: 16] == stored_i[16*g +: 16];
      assign zero_w[g] = given_i[16*g +: 16] == 16'h0000;
    end
  endgenerate

  // An all-zero password is treated as an invalid value.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      match_o <= 1'b0;
      invalid_o <= 1'b0;
    end else begin
      match_o <= &eq_w;
      invalid_o <= &zero_w;
    end
  end
endmodule // slc_pw_cmp

// *** rtl/slc_checker.sv ***
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "slc_regs.svh"
module slc_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic settings_preservation_i,
  input wire slc_pkg::slc_lba_t native_max_lba_i,
  input wire logic media_done_i,
  input wire logic media_fail_i,
  input wire logic crc_err_i,
  input wire logic sanitize_ok_i,
  output logic media_wr_o,
  output slc_pkg::slc_lba_t media_lba_o,
  output logic media_enhanced_o,
  output logic cmd_done_o,
  output logic cmd_abort_o,
  output logic cmd_fwd_o,
  output logic sanitize_frozen_state_o,
  output slc_pkg::slc_word_t id_word89_o
);
  import slc_pkg::*;

  slc_state_t state_r;
  logic [15:0] feature_r;
  logic [31:0] lba_lo_r;
  logic [15:0] lba_hi_r;
  logic [7:0] op_r;
  logic [6:0] config_r;
  slc_word_t erase_time_r;
  slc_word_t pw_mem_r [0:2*`SLC_PW_WORDS-1];
  slc_word_t pay_r [0:`SLC_PW_WORDS-1];
  logic ctl_id_r;
  logic ctl_enh_r;
  logic [8:0] word_cnt_r;
  logic prepared_r;
  logic sfrozen_r;
  logic crc_seen_r;
  logic st_done_r;
  logic st_abort_r;
  logic st_err_r;
  logic st_fwd_r;
  logic drq_r;
  slc_lba_t lba_r;
  slc_pw_t given_w;
  slc_pw_t stored_w;
  logic match_w;
  logic invalid_w;
  logic cmd_wr_w;
  logic data_wr_w;
  logic fin_w;
  logic fin_abort_w;
  logic fin_fwd_w;
  logic sec_en_w;
  logic locked_w;
  logic frozen_w;
  logic freeze_ok_w;
  logic clear_lock_w;

  assign cmd_wr_w = wr_i && addr_i == `SLC_A_CMD && state_r == SLC_IDLE;
  assign data_wr_w = wr_i && addr_i == `SLC_A_DATA && state_r == SLC_DATA;
  assign sec_en_w = config_r[`SLC_CF_SEC_EN];
  assign locked_w = config_r[`SLC_CF_LOCKED];
  assign frozen_w = config_r[`SLC_CF_FROZEN];

  // Freeze-lock acceptance checks.
  assign freeze_ok_w = config_r[`SLC_CF_SAN_SUP] && lba_lo_r == `SLC_FREEZE_KEY
    && !sfrozen_r && !config_r[`SLC_CF_ANTIFREEZE]
    && !(sec_en_w && locked_w && !frozen_w && !config_r[`SLC_CF_OVERRIDE]);

  genvar g;
  generate
    for (g = 0; g < `SLC_PW_WORDS; g++) begin : g_pw
      assign given_w[16*g +: 16] = pay_r[g];
      // Identifier picks the master copy when one.
      assign stored_w[16*g +: 16] = ctl_id_r ? pw_mem_r[`SLC_PW_WORDS + g] : pw_mem_r[g];
    end
  endgenerate

  slc_pw_cmp u_cmp (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .given_i(given_w),
    .stored_i(stored_w),
    .match_o(match_w),
    .invalid_o(invalid_w)
  );

  // Completion decisions, evaluated combinationally and registered below.
  always_comb begin
    fin_w = 1'b0;
    fin_abort_w = 1'b0;
    fin_fwd_w = 1'b0;
    clear_lock_w = 1'b0;
    if (cmd_wr_w) begin
      case (wdata_i[7:0])
        `SLC_OP_SANITIZE: begin
          fin_w = 1'b1;
          if (feature_r == `SLC_FEAT_FREEZE) begin
            fin_abort_w = !freeze_ok_w;
          end else if (feature_r == `SLC_FEAT_STATUS) begin
            fin_fwd_w = 1'b1;
          end else begin
            fin_abort_w = sfrozen_r;
            fin_fwd_w = !sfrozen_r;
          end
        end
        `SLC_OP_ERASE_PREP: begin
          fin_w = 1'b1;
          fin_abort_w = frozen_w;
        end
        `SLC_OP_DISABLE_PW: begin
          fin_w = frozen_w;
          fin_abort_w = frozen_w;
        end
        `SLC_OP_ERASE_UNIT: begin
          fin_w = frozen_w || !prepared_r;
          fin_abort_w = frozen_w || !prepared_r;
        end
        default: begin
          fin_w = 1'b1;
          fin_fwd_w = 1'b1;
        end
      endcase
    end else if (state_r == SLC_DECIDE) begin
      fin_w = 1'b1;
      if (!sec_en_w && !ctl_id_r) begin
        fin_abort_w = 1'b1;
      end else if (op_r == `SLC_OP_DISABLE_PW) begin
        fin_abort_w = !match_w;
        clear_lock_w = match_w;
      end else if (ctl_enh_r && !config_r[`SLC_CF_ENH_SUP]) begin
        fin_abort_w = 1'b1;
      end else if (sec_en_w && (!match_w || invalid_w)) begin
        fin_abort_w = 1'b1;
      end else begin
        fin_w = 1'b0;
      end
    end else if (state_r == SLC_EWAIT && media_done_i) begin
      if (media_fail_i) begin
        fin_w = 1'b1;
        fin_abort_w = 1'b1;
      end else if (lba_r == native_max_lba_i) begin
        fin_w = 1'b1;
        clear_lock_w = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= SLC_IDLE;
    end else begin
      case (state_r)
        SLC_IDLE: begin
          if (cmd_wr_w && !fin_w) begin
            state_r <= SLC_DATA;
          end
        end
        SLC_DATA: begin
          if (data_wr_w && word_cnt_r == `SLC_SECTOR_WORDS - 9'h001) begin
            state_r <= SLC_CMP;
          end
        end
        SLC_CMP: state_r <= SLC_DECIDE;
        SLC_DECIDE: state_r <= fin_w ? SLC_IDLE : SLC_ERASE;
        SLC_ERASE: state_r <= SLC_EWAIT;
        SLC_EWAIT: begin
          if (media_done_i) begin
            state_r <= fin_w ? SLC_IDLE : SLC_ERASE;
          end
        end
        default: state_r <= SLC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      feature_r <= 16'h0000;
      lba_lo_r <= 32'h00000000;
      lba_hi_r <= 16'h0000;
      erase_time_r <= `SLC_ERASE_TIME_RST;
    end else if (wr_i) begin
      // Bits 47:32 of the LBA are held but never decoded.
      case (addr_i)
        `SLC_A_FEATURE: feature_r <= wdata_i[15:0];
        `SLC_A_LBA_LO: lba_lo_r <= wdata_i;
        `SLC_A_LBA_HI: lba_hi_r <= wdata_i[15:0];
        `SLC_A_ERASE_TIME: erase_time_r <= wdata_i[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      op_r <= 8'h00;
    end else if (cmd_wr_w) begin
      op_r <= wdata_i[7:0];
    end
  end

  // Stored passwords are loaded by software; they read back as zero.
  always_ff @(posedge clock_i) begin
    if (wr_i && addr_i[7:5] == 3'(`SLC_A_PW_BASE >> 5)) begin
      pw_mem_r[addr_i[4:0]] <= wdata_i[15:0];
    end
  end

  // Sector capture keeps word 0 bits 1:0 and words 1-16 only.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      word_cnt_r <= 9'h000;
      ctl_id_r <= 1'b0;
      ctl_enh_r <= 1'b0;
    end else if (cmd_wr_w) begin
      word_cnt_r <= 9'h000;
    end else if (data_wr_w) begin
      word_cnt_r <= word_cnt_r + 9'h001;
      if (word_cnt_r == 9'h000) begin
        ctl_id_r <= wdata_i[`SLC_CTL_ID_BIT];
        ctl_enh_r <= wdata_i[`SLC_CTL_ENH_BIT];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (data_wr_w && word_cnt_r != 9'h000 && word_cnt_r <= 9'h010) begin
      pay_r[4'(word_cnt_r - 9'h001)] <= wdata_i[15:0];
    end
  end

  // Every accepted command, erase-unit included, drops the prepared flag unless it is an erase-prep while not frozen.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prepared_r <= 1'b0;
    end else if (cmd_wr_w) begin
      prepared_r <= wdata_i[7:0] == `SLC_OP_ERASE_PREP && !frozen_w;
    end
  end

  // Sanitize frozen state survives a reset while preservation is enabled.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sfrozen_r <= sfrozen_r & settings_preservation_i;
    end else if (cmd_wr_w && wdata_i[7:0] == `SLC_OP_SANITIZE
                 && feature_r == `SLC_FEAT_FREEZE && freeze_ok_w) begin
      sfrozen_r <= 1'b1;
    end
  end

  // Frozen is only set by software; hardware clears it on sanitize success,
  // and a software set in the same cycle wins.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      config_r <= `SLC_CONFIG_RST;
    end else begin
      if (clear_lock_w) begin
        config_r[`SLC_CF_SEC_EN] <= 1'b0;
        config_r[`SLC_CF_LOCKED] <= 1'b0;
      end
      if (sanitize_ok_i) begin
        config_r[`SLC_CF_FROZEN] <= 1'b0;
      end
      if (wr_i && addr_i == `SLC_A_CONFIG) begin
        config_r[5:0] <= wdata_i[5:0];
        if (wdata_i[`SLC_CF_FROZEN]) begin
          config_r[`SLC_CF_FROZEN] <= 1'b1;
        end
      end
    end
  end

  // Zero fill walks 0 to native maximum; nothing is read back.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      lba_r <= 48'h000000000000;
      media_wr_o <= 1'b0;
      media_lba_o <= 48'h000000000000;
      media_enhanced_o <= 1'b0;
    end else begin
      media_wr_o <= state_r == SLC_ERASE;
      if (state_r == SLC_DECIDE) begin
        lba_r <= 48'h000000000000;
        media_enhanced_o <= ctl_enh_r;
      end else if (state_r == SLC_EWAIT && media_done_i) begin
        lba_r <= lba_r + 48'h000000000001;
      end
      if (state_r == SLC_ERASE) begin
        media_lba_o <= lba_r;
      end
    end
  end

  // A CRC error seen during an erase-unit command flags the completion.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      crc_seen_r <= 1'b0;
    end else if (cmd_wr_w) begin
      crc_seen_r <= crc_err_i;
    end else if (crc_err_i) begin
      crc_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_done_r <= 1'b0;
      st_abort_r <= 1'b0;
      st_err_r <= 1'b0;
      st_fwd_r <= 1'b0;
      cmd_done_o <= 1'b0;
      cmd_abort_o <= 1'b0;
      cmd_fwd_o <= 1'b0;
    end else begin
      cmd_done_o <= fin_w;
      cmd_abort_o <= fin_w && fin_abort_w;
      cmd_fwd_o <= fin_w && fin_fwd_w;
      if (cmd_wr_w) begin
        st_done_r <= 1'b0;
        st_abort_r <= 1'b0;
        st_err_r <= 1'b0;
        st_fwd_r <= 1'b0;
      end
      if (fin_w) begin
        st_done_r <= 1'b1;
        st_abort_r <= fin_abort_w;
        st_fwd_r <= fin_fwd_w;
        st_err_r <= fin_abort_w || (op_r == `SLC_OP_ERASE_UNIT && (crc_seen_r || crc_err_i));
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      drq_r <= 1'b0;
      sanitize_frozen_state_o <= 1'b0;
      id_word89_o <= `SLC_ERASE_TIME_RST;
    end else begin
      drq_r <= state_r == SLC_DATA && !(data_wr_w && word_cnt_r == `SLC_SECTOR_WORDS - 9'h001)
        || cmd_wr_w && !fin_w;
      sanitize_frozen_state_o <= sfrozen_r;
      id_word89_o <= erase_time_r;
    end
  end

  // Read data stands in the cycle after the strobe; unmapped words read zero.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        `SLC_A_FEATURE: rdata_o <= {16'h0000, feature_r};
        `SLC_A_LBA_LO: rdata_o <= lba_lo_r;
        `SLC_A_LBA_HI: rdata_o <= {16'h0000, lba_hi_r};
        `SLC_A_CMD: rdata_o <= {24'h000000, op_r};
        `SLC_A_STATUS: rdata_o <= {23'h000000, st_fwd_r, frozen_w, prepared_r, sfrozen_r,
                                   st_err_r, st_abort_r, st_done_r, drq_r,
                                   state_r != SLC_IDLE};
        `SLC_A_CONFIG: rdata_o <= {25'h0000000, config_r};
        `SLC_A_ERASE_TIME: rdata_o <= {16'h0000, erase_time_r};
        default: rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule // slc_checker

// *** verif/slc_checker_asserts.sv ***
`timescale 1ns/100ps
`include "slc_regs.svh"
module slc_checker_asserts (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire slc_pkg::slc_lba_t native_max_lba_i,
  input wire logic media_done_i,
  input wire logic media_fail_i,
  input wire logic media_wr_o,
  input wire slc_pkg::slc_lba_t media_lba_o,
  input wire logic cmd_done_o,
  input wire logic cmd_abort_o,
  input wire logic cmd_fwd_o,
  input wire logic sanitize_frozen_state_o,
  input wire slc_pkg::slc_word_t id_word89_o
);
  import slc_pkg::*;
  logic first_r;
  logic busy_r;
  slc_lba_t last_r;
  logic [7:0] op_r;
  logic [15:0] feat_r;
  logic [31:0] key_r;
  always_ff @(posedge clock_i) begin
    if (rst_i || cmd_done_o) begin
      first_r <= 1'b1;
      busy_r <= 1'b0;
    end else if (media_wr_o) begin
      first_r <= 1'b0;
      busy_r <= 1'b1;
    end
    if (media_wr_o) last_r <= media_lba_o;
  end
  // The command fields are only mirrored here, so the checks judge the decode, not the bus.
  always_ff @(posedge clock_i) begin
    if (wr_i && addr_i == `SLC_A_CMD) op_r <= wdata_i[7:0];
    if (wr_i && addr_i == `SLC_A_FEATURE) feat_r <= wdata_i[15:0];
    if (wr_i && addr_i == `SLC_A_LBA_LO) key_r <= wdata_i;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_lba_bound: assert property (media_wr_o |-> media_lba_o <= native_max_lba_i)
    else $error("erase address beyond native maximum");
  a_lba_first: assert property (media_wr_o && first_r |-> media_lba_o == 48'h0)
    else $error("erase does not start at block zero");
  a_lba_step: assert property (media_wr_o && !first_r |-> media_lba_o == last_r + 48'h1)
    else $error("erase skipped or repeated a block");
  a_erase_end: assert property (busy_r && media_done_i && !media_fail_i &&
    last_r == native_max_lba_i |=> cmd_done_o && !cmd_abort_o)
    else $error("erase did not complete after last block");
  a_erase_fail: assert property (busy_r && media_done_i && media_fail_i |=>
    cmd_done_o && cmd_abort_o) else $error("failed overwrite not aborted");
  a_key_abort: assert property (cmd_done_o && op_r == `SLC_OP_SANITIZE &&
    feat_r == `SLC_FEAT_FREEZE && key_r != `SLC_FREEZE_KEY |-> cmd_abort_o)
    else $error("wrong freeze key accepted");
  a_frozen_abort: assert property (cmd_done_o && op_r == `SLC_OP_SANITIZE &&
    feat_r != `SLC_FEAT_STATUS && $past(sanitize_frozen_state_o) |-> cmd_abort_o && !cmd_fwd_o)
    else $error("sanitize accepted while frozen");
  a_status_pass: assert property (cmd_done_o && op_r == `SLC_OP_SANITIZE &&
    feat_r == `SLC_FEAT_STATUS |-> !cmd_abort_o) else $error("status query aborted");
  a_fwd_done: assert property (cmd_fwd_o |-> cmd_done_o && !cmd_abort_o)
    else $error("forward without clean completion");
  a_time_word: assert property (wr_i && addr_i == `SLC_A_ERASE_TIME |-> ##2
    id_word89_o == slc_word_t'($past(wdata_i, 2))) else $error("erase time word not updated");
endmodule // slc_checker_asserts
bind slc_checker slc_checker_asserts u_slc_checker_asserts (.clock_i, .rst_i, .addr_i,
  .wdata_i, .wr_i, .native_max_lba_i, .media_done_i, .media_fail_i, .media_wr_o,
  .media_lba_o, .cmd_done_o, .cmd_abort_o, .cmd_fwd_o, .sanitize_frozen_state_o, .id_word89_o);

// *** verif/slc_media_model.sv ***
`timescale 1ns/100ps
module slc_media_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic media_wr_i,
  input wire logic slow_i,
  input wire logic fail_en_i,
  input wire slc_pkg::slc_lba_t lba_i,
  input wire slc_pkg::slc_lba_t fail_lba_i,
  output logic done_o,
  output logic fail_o
);
  import slc_pkg::*;
  logic [3:0] cnt_r;
  logic pend_r;
  logic tog_r;
  slc_lba_t lba_r;
  // Zeros are written blind; nothing is read back to verify them.
  always_ff @(posedge clock_i) begin
    done_o <= 1'b0;
    tog_r <= rst_i ? 1'b0 : ~tog_r;
    if (rst_i) begin
      pend_r <= 1'b0;
    end else if (media_wr_i) begin
      pend_r <= 1'b1;
      lba_r <= lba_i;
      cnt_r <= slow_i ? 4'hC : 4'h1;
    end else if (pend_r) begin
      if (cnt_r == 4'h0) begin
        pend_r <= 1'b0;
        done_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
  // Outside the done pulse the fail line wiggles, so a stale level cannot pass for an answer.
  assign fail_o = done_o ? (fail_en_i && lba_r == fail_lba_i) : tog_r;
endmodule // slc_media_model

// *** verif/test_slc_checker.sv ***
`timescale 1ns/100ps
`include "slc_regs.svh"
module test_slc_checker;
  import slc_pkg::*;
  typedef struct packed {logic [7:0] cfg; logic [15:0] feat; logic [31:0] key; logic [2:0] ex;} slc_row_t;
  localparam logic [31:0] k_key = `SLC_FREEZE_KEY;
  localparam logic [15:0] k_frz = `SLC_FEAT_FREEZE;
  logic clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic settings_preservation_i = 1'b0, crc_err_i = 1'b0, sanitize_ok_i = 1'b0;
  logic slow = 1'b0, fail_en = 1'b0, enh_seen = 1'b0, ab, fw;
  logic media_done_i, media_fail_i, media_wr_o, media_enhanced_o;
  logic cmd_done_o, cmd_abort_o, cmd_fwd_o, sanitize_frozen_state_o;
  slc_lba_t native_max_lba_i = 48'h3, media_lba_o;
  slc_word_t id_word89_o;
  int err_total = 0, check_count = 0, wcount = 0, w0;
  slc_row_t rows [9];
  always #2 clock_i = ~clock_i;
  always @(negedge clock_i) if (media_wr_o === 1'b1) begin
    wcount++;
    enh_seen = media_enhanced_o;
  end
  slc_checker u_slc_checker (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .settings_preservation_i, .native_max_lba_i, .media_done_i, .media_fail_i, .crc_err_i,
    .sanitize_ok_i, .media_wr_o, .media_lba_o, .media_enhanced_o, .cmd_done_o, .cmd_abort_o,
    .cmd_fwd_o, .sanitize_frozen_state_o, .id_word89_o);
  slc_media_model u_slc_media_model (.clock_i, .rst_i, .media_wr_i(media_wr_o), .slow_i(slow),
    .fail_en_i(fail_en), .lba_i(media_lba_o), .fail_lba_i(native_max_lba_i),
    .done_o(media_done_i), .fail_o(media_fail_i));
  task conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i) {addr_i, wdata_i, wr_i} <= {a, v, 1'b1};
    @(posedge clock_i) wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clock_i) rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task rst(input logic p);
    @(posedge clock_i) {settings_preservation_i, rst_i} <= {p, 1'b1};
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  // Sends the command; a data command also gets its one-sector payload.
  task cmd(input logic [7:0] op, input logic [15:0] ctl, input logic [15:0] base,
      input logic [15:0] flip, input logic data, input logic crc);
    int i;
    wr(`SLC_A_CMD, {24'h0, op});
    if (crc) @(posedge clock_i) crc_err_i <= 1'b1;
    if (crc) @(posedge clock_i) crc_err_i <= 1'b0;
    if (data) begin
      rd(`SLC_A_STATUS);
      chk(d[`SLC_ST_DRQ], 1);
      wr(`SLC_A_DATA, {16'h0, ctl});
      for (i = 1; i < 256; i++) wr(`SLC_A_DATA, i > 16 ? 32'hFFFF : base + i ^ (i == 16 ? flip : 0));
    end
    for (i = 0; i < 3000; i++) begin
      #1;
      if (cmd_done_o === 1'b1) break;
      @(posedge clock_i);
    end
    {ab, fw} = {cmd_abort_o, cmd_fwd_o};
    if (i == 3000) begin
      err_total++;
      $display("mismatch at %0t: no completion", $time);
      conclude;
    end
  endtask
  initial begin
    rows = '{'{8'h00, k_frz, k_key, 3'h4}, '{8'h03, k_frz, k_key, 3'h4},
      '{8'h31, k_frz, k_key, 3'h4}, '{8'h01, k_frz, k_key ^ 32'h1, 3'h4},
      '{8'h01, 16'h0000, k_key, 3'h2}, '{8'h35, k_frz, k_key, 3'h1},
      '{8'h01, k_frz, k_key, 3'h5}, '{8'h01, 16'h0014, k_key, 3'h5},
      '{8'h01, 16'h0000, k_key, 3'h3}};
    rst(1'b0);
    foreach (rows[r]) begin
      wr(`SLC_A_CONFIG, rows[r].cfg);
      wr(`SLC_A_FEATURE, rows[r].feat);
      wr(`SLC_A_LBA_LO, rows[r].key);
      cmd(`SLC_OP_SANITIZE, 0, 0, 0, 0, 0);
      rd(`SLC_A_STATUS);
      chk({ab, fw, d[`SLC_ST_SFROZEN]}, rows[r].ex);
    end
    rst(1'b1);
    chk(sanitize_frozen_state_o, 1);
    rst(1'b0);
    chk(sanitize_frozen_state_o, 0);
    for (int k = 1; k <= 16; k++) wr(8'h1F + k, 32'h1100 + k);
    for (int k = 1; k <= 16; k++) wr(8'h2F + k, 32'h2200 + k);
    wr(`SLC_A_CONFIG, 8'h19);
    cmd(`SLC_OP_ERASE_UNIT, 0, 0, 0, 0, 0);
    chk(ab, 1);
    cmd(`SLC_OP_ERASE_PREP, 0, 0, 0, 0, 0);
    rd(`SLC_A_STATUS);
    chk({ab, d[`SLC_ST_PREP]}, 2'b01);
    cmd(`SLC_OP_SANITIZE, 0, 0, 0, 0, 0);
    cmd(`SLC_OP_ERASE_UNIT, 0, 0, 0, 0, 0);
    chk(ab, 1);
    cmd(`SLC_OP_DISABLE_PW, 0, 16'h1100, 16'h0100, 1, 0);
    chk(ab, 1);
    cmd(`SLC_OP_DISABLE_PW, 16'hFFFE, 16'h1100, 0, 1, 0);
    chk(ab, 0);
    cmd(`SLC_OP_DISABLE_PW, 0, 16'h1100, 0, 1, 0);
    chk(ab, 1);
    slow <= 1'b1;
    w0 = wcount;
    cmd(`SLC_OP_ERASE_PREP, 0, 0, 0, 0, 0);
    cmd(`SLC_OP_ERASE_UNIT, 16'hFFFF, 16'h7700, 0, 1, 1);
    rd(`SLC_A_STATUS);
    chk({ab, d[`SLC_ST_ERR], enh_seen, 8'(wcount - w0)}, {3'b011, 8'd4});
    slow <= 1'b0;
    cmd(`SLC_OP_ERASE_PREP, 0, 0, 0, 0, 0);
    cmd(`SLC_OP_ERASE_UNIT, 0, 16'h1100, 0, 1, 0);
    chk(ab, 1);
    wr(`SLC_A_CONFIG, 8'h11);
    cmd(`SLC_OP_ERASE_PREP, 0, 0, 0, 0, 0);
    cmd(`SLC_OP_ERASE_UNIT, 16'h0002, 16'h1100, 0, 1, 0);
    chk(ab, 1);
    wr(`SLC_A_CONFIG, 8'h19);
    fail_en <= 1'b1;
    cmd(`SLC_OP_ERASE_PREP, 0, 0, 0, 0, 0);
    cmd(`SLC_OP_ERASE_UNIT, 0, 16'h1100, 0, 1, 0);
    chk(ab, 1);
    fail_en <= 1'b0;
    w0 = wcount;
    cmd(`SLC_OP_ERASE_PREP, 0, 0, 0, 0, 0);
    cmd(`SLC_OP_ERASE_UNIT, 16'h0001, 16'h2200, 0, 1, 0);
    chk({ab, enh_seen, 8'(wcount - w0)}, {2'b00, 8'd4});
    cmd(`SLC_OP_DISABLE_PW, 0, 16'h1100, 0, 1, 0);
    chk(ab, 1);
    wr(`SLC_A_CONFIG, 8'h40);
    cmd(`SLC_OP_ERASE_PREP, 0, 0, 0, 0, 0);
    chk(ab, 1);
    @(posedge clock_i) sanitize_ok_i <= 1'b1;
    @(posedge clock_i) sanitize_ok_i <= 1'b0;
    rd(`SLC_A_CONFIG);
    chk(d[`SLC_CF_FROZEN], 0);
    cmd(`SLC_OP_ERASE_PREP, 0, 0, 0, 0, 0);
    chk(ab, 0);
    wr(`SLC_A_ERASE_TIME, 32'h1234);
    rd(`SLC_A_ERASE_TIME);
    chk({d[15:0], id_word89_o}, 32'h12341234);
    rd(8'h50);
    chk(d, 32'h0);
    conclude;
  end
endmodule // test_slc_checker
